// [hdl/sdp_pkg.sv]
// shared constants and types for the dual element simd datapath
package sdp_pkg;
  localparam int WORD_W = 32;
  localparam int EXT_W = 40;
  localparam int INSTR_W = 48;
  localparam int FETCH_W = 16;
  localparam int REGS_PER_BANK = 16;
  localparam int RF_DEPTH = 32;
  localparam int DAG_SETS = 16;
  localparam int CACHE_DEPTH = 16;
  // mode control register layout
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam int MODE_PEY_BIT = 0;
  localparam int MODE_RSEC_BIT = 1;
  localparam int MODE_DSEC_BIT = 2;
  // float format constants
  localparam logic [9:0] F_BIAS = 10'h07f;
  localparam logic [7:0] F_EXP_MAX = 8'hff;
  localparam logic [7:0] H_OFFSET = 8'h70;
  localparam logic [7:0] H_MIN = 8'h71;
  localparam logic [7:0] H_MAX = 8'h8e;

  typedef enum logic [2:0] {
    CLS_NOP, CLS_COMPUTE, CLS_MULTI, CLS_BFLY, CLS_LOAD, CLS_STORE, CLS_DAGLD
  } sdp_cls_t;

  typedef enum logic [2:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_PASS, ALU_TO16, ALU_TO32
  } sdp_alu_t;

  typedef enum logic [1:0] {FMT_FIXED, FMT_FLOAT, FMT_EXT} sdp_fmt_t;

  typedef struct packed {
    sdp_cls_t cls;
    sdp_alu_t op;
    sdp_fmt_t fmt;
    logic cond;
    logic branch;
    logic [3:0] rd;
    logic [3:0] rx;
    logic [3:0] ry;
    logic [3:0] ra;
    logic dual_bus;
    logic [2:0] ptr;
    logic [17:0] imm;
  } sdp_instr_t;

  typedef struct packed {
    logic req;
    logic we;
    logic pair;
    logic [31:0] addr;
    logic [63:0] wdata;
  } sdp_mem_req_t;
endpackage

// [hdl/sdp_datapath.sv]
// dual element simd datapath with address generators and selective cache
`timescale 1ns/1ps
`default_nettype none
module sdp_datapath (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // primary mode control register
  input wire logic mode_wr,
  input wire logic [31:0] mode_wdata,
  output logic [31:0] mode_q,
  // instruction fetch
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic pm_conflict,
  input wire logic [47:0] mem_instr,
  output logic fetch_stall,
  output logic branch_taken,
  output logic [15:0] branch_target,
  // data memory bus and program memory bus
  output sdp_pkg::sdp_mem_req_t dm_bus,
  output sdp_pkg::sdp_mem_req_t pm_bus,
  input wire logic [63:0] dm_rdata,
  input wire logic [63:0] pm_rdata,
  // status
  output logic [1:0] pe_zero
);
  function automatic logic [39:0] fmul(input logic [39:0] a, input logic [39:0] b);
    logic [63:0] prod;
    logic [9:0] e;
    logic s;
    prod = 64'({1'b1, a[30:0]}) * 64'({1'b1, b[30:0]});
    e = 10'(a[38:31]) + 10'(b[38:31]) - sdp_pkg::F_BIAS + 10'(prod[63]);
    s = a[39] ^ b[39];
    if (a[38:31] == 8'h00 || b[38:31] == 8'h00 || e[9])
      fmul = {s, 39'h0};
    else if (e[8] || e[7:0] == sdp_pkg::F_EXP_MAX)
      fmul = {s, sdp_pkg::F_EXP_MAX, 31'h0};
    else
      fmul = {s, e[7:0], prod[63] ? prod[62:32] : prod[61:31]};
  endfunction

  function automatic logic [15:0] to_half(input logic [31:0] a);
    if (a[30:23] < sdp_pkg::H_MIN)
      to_half = {a[31], 15'h0};
    else if (a[30:23] > sdp_pkg::H_MAX)
      to_half = {a[31], 5'h1f, 10'h0};
    else
      to_half = {a[31], 5'(a[30:23] - sdp_pkg::H_OFFSET), a[22:13]};
  endfunction

  function automatic logic [31:0] to_single(input logic [15:0] a);
    if (a[14:10] == 5'h00)
      to_single = {a[15], 31'h0};
    else
      to_single = {a[15], 8'(a[14:10]) + sdp_pkg::H_OFFSET, a[9:0], 13'h0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // mode control
  logic pey_en;
  logic rbank;
  logic dbank;
  assign pey_en = mode_q[sdp_pkg::MODE_PEY_BIT];
  assign rbank = mode_q[sdp_pkg::MODE_RSEC_BIT];
  assign dbank = mode_q[sdp_pkg::MODE_DSEC_BIT];

  always_ff @(posedge core_clk) begin
    if (reset)
      mode_q <= sdp_pkg::MODE_RESET;
    else if (mode_wr)
      mode_q <= mode_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // selective instruction cache
  logic [47:0] cache_data [sdp_pkg::CACHE_DEPTH];
  logic [11:0] cache_tag [sdp_pkg::CACHE_DEPTH];
  logic [15:0] cache_valid;
  logic [3:0] cidx;
  logic hit;
  logic use_mem;
  logic issue;
  logic miss;
  sdp_pkg::sdp_instr_t ins;
  assign cidx = fetch_addr[3:0];
  assign hit = cache_valid[cidx] && cache_tag[cidx] == fetch_addr[15:4];
  // after a miss stall the bus data access has moved, so the word comes from memory
  assign use_mem = !pm_conflict || fetch_stall;
  assign issue = fetch_valid && (use_mem || hit);
  assign miss = fetch_valid && pm_conflict && !hit && !fetch_stall;
  assign ins = sdp_pkg::sdp_instr_t'(use_mem ? mem_instr : cache_data[cidx]);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      fetch_stall <= 1'b0;
      cache_valid <= 16'h0000;
    end else begin
      fetch_stall <= miss;
      if (fetch_valid && fetch_stall)
        cache_valid[cidx] <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (fetch_valid && fetch_stall) begin
      cache_data[cidx] <= mem_instr;
      cache_tag[cidx] <= fetch_addr[15:4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address generators
  logic mem_op;
  logic [31:0] dag_addr [2];
  assign mem_op = issue && (ins.cls == sdp_pkg::CLS_LOAD || ins.cls == sdp_pkg::CLS_STORE);

  for (genvar d = 0; d < 2; d++) begin : g_dag
    logic [31:0] idx [sdp_pkg::DAG_SETS];
    logic [31:0] base [sdp_pkg::DAG_SETS];
    logic [31:0] len [sdp_pkg::DAG_SETS];
    logic [3:0] set;
    logic [31:0] modv;
    logic [31:0] nxt;
    logic [31:0] endv;
    logic [31:0] wrapped;
    logic upd;
    logic ld;
    assign set = {dbank, ins.ptr};
    assign modv = {{14{ins.imm[17]}}, ins.imm};
    assign nxt = idx[set] + modv;
    assign endv = base[set] + len[set];
    assign upd = mem_op && (d == 0 || ins.dual_bus);
    assign ld = issue && ins.cls == sdp_pkg::CLS_DAGLD && ins.dual_bus == 1'(d);
    assign dag_addr[d] = idx[set];
    always_comb begin
      if (len[set] == 32'h0)
        wrapped = nxt;
      else if (nxt >= endv)
        wrapped = nxt - len[set];
      else if (nxt < base[set])
        wrapped = nxt + len[set];
      else
        wrapped = nxt;
    end
    always_ff @(posedge core_clk) begin
      if (ld && ins.op[1:0] == 2'h0)
        idx[set] <= {14'h0, ins.imm};
      else if (upd)
        idx[set] <= wrapped;
      if (ld && ins.op[1:0] == 2'h1)
        base[set] <= {14'h0, ins.imm};
      if (ld && ins.op[1:0] == 2'h2)
        len[set] <= {14'h0, ins.imm};
    end
    AST_CIRC_WRAP: assert property (@(posedge core_clk) disable iff (reset)
      (upd && len[set] != 32'h0 && idx[set] >= base[set] && idx[set] < endv
       && (modv < len[set] || -modv < len[set]))
      |-> (wrapped >= base[set] && wrapped < endv))
      else $error("circular pointer left its buffer");
  end

  ////////////////////////////////////////////////////////////////////////////
  // processing elements
  logic ld_dm_reg;
  logic ld_pm_reg;
  logic ld_pair_reg;
  logic [4:0] ld_rd_reg;
  logic [4:0] ld_ra_reg;
  logic [31:0] st_dm [2];
  logic [31:0] st_pm [2];
  logic [31:0] alu32 [2];
  logic [1:0] cond_ok;

  for (genvar p = 0; p < 2; p++) begin : g_pe
    logic [39:0] rf [sdp_pkg::RF_DEPTH];
    logic [39:0] a;
    logic [39:0] b;
    logic [39:0] mul;
    logic [39:0] fm;
    logic [31:0] diff;
    logic active;
    logic exec;
    logic zero_reg;
    assign a = rf[{rbank, ins.rx}];
    assign b = rf[{rbank, ins.ry}];
    assign diff = a[39:8] - b[39:8];
    assign fm = fmul(a, b);
    assign st_dm[p] = rf[{rbank, ins.rd}][39:8];
    assign st_pm[p] = rf[{rbank, ins.ra}][39:8];
    assign active = (p == 0) || pey_en;
    assign cond_ok[p] = !ins.cond || !zero_reg;
    assign exec = issue && active && cond_ok[p];
    assign pe_zero[p] = zero_reg;

    always_comb begin
      case (ins.op)
        sdp_pkg::ALU_ADD: alu32[p] = a[39:8] + b[39:8];
        sdp_pkg::ALU_SUB: alu32[p] = diff;
        sdp_pkg::ALU_AND: alu32[p] = a[39:8] & b[39:8];
        sdp_pkg::ALU_OR: alu32[p] = a[39:8] | b[39:8];
        sdp_pkg::ALU_XOR: alu32[p] = a[39:8] ^ b[39:8];
        sdp_pkg::ALU_TO16: alu32[p] = {16'h0000, to_half(a[39:8])};
        sdp_pkg::ALU_TO32: alu32[p] = to_single(a[23:8]);
        default: alu32[p] = a[39:8];
      endcase
    end

    always_comb begin
      case (ins.fmt)
        sdp_pkg::FMT_FLOAT: mul = {fm[39:8], 8'h00};
        sdp_pkg::FMT_EXT: mul = fm;
        default: mul = {32'(a[39:8] * b[39:8]), 8'h00};
      endcase
    end

    always_ff @(posedge core_clk) begin
      if (ld_dm_reg && (p == 0 || ld_pair_reg))
        rf[ld_rd_reg] <= {dm_rdata[p*32 +: 32], 8'h00};
      if (ld_pm_reg && (p == 0 || ld_pair_reg))
        rf[ld_ra_reg] <= {pm_rdata[p*32 +: 32], 8'h00};
      if (exec) begin
        case (ins.cls)
          sdp_pkg::CLS_COMPUTE: rf[{rbank, ins.rd}] <= {alu32[p], 8'h00};
          sdp_pkg::CLS_MULTI: begin
            rf[{rbank, ins.rd}] <= {alu32[p], 8'h00};
            rf[{rbank, ins.ra}] <= mul;
          end
          sdp_pkg::CLS_BFLY: begin
            rf[{rbank, ins.rd}] <= {32'(a[39:8] + b[39:8]), 8'h00};
            rf[{rbank, ins.ra}] <= {diff, 8'h00};
            rf[{rbank, ins.imm[3:0]}] <= mul;
          end
          default: ;
        endcase
      end
    end

    always_ff @(posedge core_clk) begin
      if (reset)
        zero_reg <= 1'b0;
      else if (exec && (ins.cls == sdp_pkg::CLS_COMPUTE || ins.cls == sdp_pkg::CLS_MULTI))
        zero_reg <= alu32[p] == 32'h0;
      else if (exec && ins.cls == sdp_pkg::CLS_BFLY)
        zero_reg <= diff == 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory transfers and branch
  // loaded data returns one cycle after the request
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ld_dm_reg <= 1'b0;
      ld_pm_reg <= 1'b0;
      ld_pair_reg <= 1'b0;
      ld_rd_reg <= 5'h00;
      ld_ra_reg <= 5'h00;
    end else begin
      ld_dm_reg <= issue && ins.cls == sdp_pkg::CLS_LOAD;
      ld_pm_reg <= issue && ins.cls == sdp_pkg::CLS_LOAD && ins.dual_bus;
      ld_pair_reg <= pey_en;
      ld_rd_reg <= {rbank, ins.rd};
      ld_ra_reg <= {rbank, ins.ra};
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      dm_bus <= '0;
      pm_bus <= '0;
    end else begin
      dm_bus.req <= mem_op;
      dm_bus.we <= mem_op && ins.cls == sdp_pkg::CLS_STORE;
      dm_bus.pair <= mem_op && pey_en;
      dm_bus.addr <= dag_addr[0];
      dm_bus.wdata <= {pey_en ? st_dm[1] : 32'h0, st_dm[0]};
      pm_bus.req <= mem_op && ins.dual_bus;
      pm_bus.we <= mem_op && ins.dual_bus && ins.cls == sdp_pkg::CLS_STORE;
      pm_bus.pair <= mem_op && ins.dual_bus && pey_en;
      pm_bus.addr <= dag_addr[1];
      pm_bus.wdata <= {pey_en ? st_pm[1] : 32'h0, st_pm[0]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      branch_taken <= 1'b0;
      branch_target <= 16'h0000;
    end else begin
      branch_taken <= issue && ins.branch && cond_ok[0];
      branch_target <= ins.imm[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_PEY_FROZEN: assert property (@(posedge core_clk) disable iff (reset)
    !pey_en && !mode_wr |=> $stable(pe_zero[1]))
    else $error("disabled second element changed state");
  AST_PEX_RUNS: assert property (@(posedge core_clk) disable iff (reset)
    issue && ins.cls == sdp_pkg::CLS_COMPUTE && !ins.cond
    |=> pe_zero[0] == ($past(alu32[0]) == 32'h0))
    else $error("first element did not execute");
  AST_SIMD_BOTH: assert property (@(posedge core_clk) disable iff (reset)
    issue && pey_en && ins.cls == sdp_pkg::CLS_MULTI && !ins.cond
    |=> pe_zero[1] == ($past(alu32[1]) == 32'h0))
    else $error("second element missed a simd instruction");
  AST_DUAL_PAIR: assert property (@(posedge core_clk) disable iff (reset)
    mem_op |=> dm_bus.req && dm_bus.pair == $past(pey_en))
    else $error("pair flag does not follow element mode");
  AST_FOUR_OPERANDS: assert property (@(posedge core_clk) disable iff (reset)
    mem_op && ins.dual_bus && pey_en |=> dm_bus.pair && pm_bus.pair && pm_bus.req)
    else $error("both buses not used together");
  AST_NO_CACHE_FILL: assert property (@(posedge core_clk) disable iff (reset)
    !fetch_stall |=> cache_valid == $past(cache_valid))
    else $error("cache filled without a conflict");
  AST_MISS_STALL: assert property (@(posedge core_clk) disable iff (reset)
    miss |=> fetch_stall ##1 !fetch_stall)
    else $error("conflict miss stall not exactly one cycle");
  AST_BRANCH: assert property (@(posedge core_clk) disable iff (reset)
    issue && ins.branch && !ins.cond
    |=> branch_taken && branch_target == $past(ins.imm[15:0]))
    else $error("unconditional branch not taken");
endmodule // sdp_datapath
`default_nettype wire

// [verif/sdp_datapath_tb_top.sv]
// self-checking bench for the dual element simd datapath
`timescale 1ns/1ps
`default_nettype none
module sdp_datapath_tb_top;
  logic core_clk, reset, mode_wr, fetch_valid, pm_conflict, fetch_stall, branch_taken;
  logic [31:0] mode_wdata, mode_q;
  logic [15:0] fetch_addr, branch_target;
  logic [47:0] mem_instr;
  sdp_pkg::sdp_mem_req_t dm_bus, pm_bus;
  logic [63:0] dm_rdata, pm_rdata;
  logic [1:0] pe_zero;
  int n_fail = 0;
  int tests_run = 0;

  sdp_datapath dut (.core_clk(core_clk), .reset(reset), .mode_wr(mode_wr),
    .mode_wdata(mode_wdata), .mode_q(mode_q), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .pm_conflict(pm_conflict), .mem_instr(mem_instr),
    .fetch_stall(fetch_stall), .branch_taken(branch_taken),
    .branch_target(branch_target), .dm_bus(dm_bus), .pm_bus(pm_bus),
    .dm_rdata(dm_rdata), .pm_rdata(pm_rdata), .pe_zero(pe_zero));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  function automatic sdp_pkg::sdp_instr_t mk(input logic [2:0] c, input logic [2:0] o,
      input logic [3:0] d, input logic [3:0] x, input logic [3:0] y, input logic [3:0] a,
      input logic [17:0] im);
    mk = '0;
    mk.cls = sdp_pkg::sdp_cls_t'(c);
    mk.op = sdp_pkg::sdp_alu_t'(o);
    mk.rd = d;
    mk.rx = x;
    mk.ry = y;
    mk.ra = a;
    mk.dual_bus = 1'b1;
    mk.imm = im;
  endfunction

  // fetch stays up after the edge; ld drops it at once, other callers follow with another issue, idle or setm
  task automatic issue(input sdp_pkg::sdp_instr_t i, input logic [15:0] a = 16'h0000,
      input logic c = 1'b0);
    fetch_valid = 1'b1;
    mem_instr = i;
    fetch_addr = a;
    pm_conflict = c;
    @(negedge core_clk);
  endtask

  task automatic idle();
    fetch_valid = 1'b0;
    pm_conflict = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic setm(input logic [31:0] v);
    mode_wr = 1'b1;
    mode_wdata = v;
    @(negedge core_clk);
    mode_wr = 1'b0;
    chk(64'(mode_q), 64'(v));
    @(negedge core_clk);
  endtask

  task automatic agl(input logic g, input logic [2:0] p, input logic [2:0] o,
      input logic [17:0] v);
    sdp_pkg::sdp_instr_t i;
    i = mk(3'h6, o, 4'h0, 4'h0, 4'h0, 4'h0, v);
    i.dual_bus = g;
    i.ptr = p;
    issue(i);
  endtask

  task automatic ld(input logic [3:0] d, input logic [3:0] a, input logic [2:0] p,
      input logic [17:0] m, input logic [31:0] ea, input logic [63:0] dv,
      input logic [63:0] pv);
    sdp_pkg::sdp_instr_t i;
    i = mk(3'h4, 3'h0, d, 4'h0, 4'h0, a, m);
    i.ptr = p;
    issue(i);
    fetch_valid = 1'b0;
    dm_rdata = dv;
    pm_rdata = pv;
    chk({dm_bus.req, pm_bus.req, dm_bus.we, pm_bus.we, dm_bus.pair, pm_bus.pair, dm_bus.addr},
      {4'b1100, mode_q[0], mode_q[0], ea});
    @(negedge core_clk);
    // released bus must not keep looking valid
    dm_rdata = ~dv;
    pm_rdata = ~pv;
  endtask

  task automatic st(input logic [3:0] d, input logic [3:0] a, input logic [63:0] e,
      input logic [63:0] f);
    issue(mk(3'h5, 3'h0, d, 4'h0, 4'h0, a, 18'h0));
    chk({dm_bus.req, dm_bus.we, pm_bus.req, pm_bus.we}, 4'hf);
    chk(dm_bus.wdata, e);
    chk(pm_bus.wdata, f);
  endtask
////////////////////////////////////////////////////////////////
  task automatic t_simd();
    setm(32'h1);
    ld(4'h1, 4'h2, 3'h0, 18'h0, 32'h0, 64'hb0b0_0001_a0a0_0001, 64'hd0d0_0001_c0c0_0001);
    setm(32'h0);
    ld(4'h1, 4'h2, 3'h0, 18'h0, 32'h0, 64'hf0f0_0001_e0e0_0001, 64'h1212_0001_3434_0001);
    setm(32'h1);
    st(4'h1, 4'h2, 64'hb0b0_0001_e0e0_0001, 64'hd0d0_0001_3434_0001);
    // secondary register bank must not disturb the primary one
    setm(32'h3);
    ld(4'h1, 4'h2, 3'h0, 18'h0, 32'h0, 64'h5555_0001_6666_0001, 64'h7777_0001_8888_0001);
    st(4'h1, 4'h2, 64'h5555_0001_6666_0001, 64'h7777_0001_8888_0001);
    setm(32'h1);
    st(4'h1, 4'h2, 64'hb0b0_0001_e0e0_0001, 64'hd0d0_0001_3434_0001);
    idle();
  endtask

  // back to back, no gaps between dependent results
  task automatic t_alu();
    ld(4'h1, 4'h2, 3'h0, 18'h0, 32'h0, 64'h10_0000_0007, 64'h3_0000_0005);
    issue(mk(3'h1, 3'h0, 4'h3, 4'h1, 4'h2, 4'h0, 18'h0));
    issue(mk(3'h2, 3'h1, 4'h4, 4'h1, 4'h2, 4'h5, 18'h0));
    issue(mk(3'h3, 3'h0, 4'h6, 4'h1, 4'h2, 4'h7, 18'h0));
    st(4'h3, 4'h5, 64'h13_0000_000c, 64'h30_0000_0023);
    st(4'h4, 4'h6, 64'h0d_0000_0002, 64'h13_0000_000c);
    st(4'h6, 4'h7, 64'h13_0000_000c, 64'h0d_0000_0002);
    idle();
  endtask

  task automatic t_cond();
    sdp_pkg::sdp_instr_t i;
    ld(4'he, 4'hf, 3'h0, 18'h0, 32'h0, 64'h1_0000_0000, 64'h0);
    issue(mk(3'h1, 3'h5, 4'he, 4'he, 4'h0, 4'h0, 18'h0));
    chk(64'(pe_zero), 64'h1);
    i = mk(3'h1, 3'h0, 4'he, 4'h1, 4'h1, 4'h0, 18'h0);
    i.cond = 1'b1;
    issue(i);
    st(4'he, 4'hf, 64'h20_0000_0000, 64'h0);
    idle();
  endtask

  // odd base and length, crossing the end must wrap
  task automatic t_circ();
    agl(1'b0, 3'h1, 3'h1, 18'h13);
    agl(1'b0, 3'h1, 3'h2, 18'h3);
    agl(1'b0, 3'h1, 3'h0, 18'h15);
    idle();
    ld(4'h1, 4'h2, 3'h1, 18'h1, 32'h15, 64'h0, 64'h0);
    ld(4'h1, 4'h2, 3'h1, 18'h1, 32'h13, 64'h0, 64'h0);
    setm(32'h5);
    agl(1'b0, 3'h1, 3'h1, 18'h0);
    agl(1'b0, 3'h1, 3'h2, 18'h0);
    agl(1'b0, 3'h1, 3'h0, 18'h2a);
    idle();
    ld(4'h1, 4'h2, 3'h1, 18'h1, 32'h2a, 64'h0, 64'h0);
    setm(32'h1);
    ld(4'h1, 4'h2, 3'h1, 18'h1, 32'h14, 64'h0, 64'h0);
  endtask

  task automatic t_cache();
    sdp_pkg::sdp_instr_t b;
    b = mk(3'h0, 3'h0, 4'h0, 4'h0, 4'h0, 4'h0, 18'habc);
    b.branch = 1'b1;
    issue(b, 16'h40, 1'b1);
    chk({fetch_stall, branch_taken}, 2'b10);
    issue(b, 16'h40, 1'b1);
    chk({fetch_stall, branch_taken, branch_target}, {2'b01, 16'h0abc});
    issue(b, 16'h50, 1'b0);
    issue('0, 16'h40, 1'b1);
    chk({fetch_stall, branch_taken}, 2'b01);
    issue(b, 16'h50, 1'b1);
    chk({fetch_stall, branch_taken}, 2'b10);
    issue(b, 16'h50, 1'b1);
    idle();
  endtask

  task automatic t_fp();
    sdp_pkg::sdp_instr_t i;
    ld(4'h8, 4'h9, 3'h0, 18'h0, 32'h0, 64'hc000_0000_3f80_0000, 64'h0);
    issue(mk(3'h1, 3'h6, 4'h9, 4'h8, 4'h0, 4'h0, 18'h0));
    issue(mk(3'h1, 3'h7, 4'ha, 4'h9, 4'h0, 4'h0, 18'h0));
    i = mk(3'h2, 3'h5, 4'hb, 4'h8, 4'h8, 4'hc, 18'h0);
    i.fmt = sdp_pkg::FMT_FLOAT;
    issue(i);
    i.fmt = sdp_pkg::FMT_EXT;
    i.ra = 4'hd;
    issue(i);
    st(4'h9, 4'ha, 64'h0000_c000_0000_3c00, 64'hc000_0000_3f80_0000);
    st(4'hc, 4'hd, 64'h4080_0000_3f80_0000, 64'h4080_0000_3f80_0000);
    idle();
  endtask
////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_fail++;
    final_report();
  end

  initial begin
    reset = 1'b1;
    mode_wr = 1'b0;
    mode_wdata = '0;
    fetch_valid = 1'b0;
    fetch_addr = '0;
    pm_conflict = 1'b0;
    mem_instr = '0;
    dm_rdata = '0;
    pm_rdata = '0;
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    chk({mode_q, dm_bus.req, pm_bus.req, fetch_stall, branch_taken, pe_zero}, '0);
    // generator registers have no reset
    for (int g = 0; g < 2; g++) begin
      for (int p = 0; p < 2; p++) begin
        for (int o = 0; o < 3; o++) begin
          agl(g[0], p[2:0], o[2:0], 18'h0);
        end
      end
    end
    idle();
    t_simd();
    t_alu();
    t_cond();
    t_circ();
    t_cache();
    t_fp();
    final_report();
  end
endmodule // sdp_datapath_tb_top
`default_nettype wire
